// ### rtl/tcu_map.svh
/*
 * Address map, field positions, codes and reset values of the 8-bit
 * timer/counter with two compare channels.
 * Assumes a 32-bit APB slave with byte addresses in an 8-bit field.
 */
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH

// register byte offsets
`define TCU_OFF_CTRL_A 8'h00
`define TCU_OFF_CTRL_B 8'h04
`define TCU_OFF_COUNT 8'h08
`define TCU_OFF_CMP_A 8'h0C
`define TCU_OFF_CMP_B 8'h10
`define TCU_OFF_FLAGS 8'h14
`define TCU_OFF_IRQ_EN 8'h18
`define TCU_OFF_PORT 8'h1C

// control_reg_a fields
`define TCU_A_COM_A 7:6
`define TCU_A_COM_B 5:4
`define TCU_A_WGM 1:0
// control_reg_b fields
`define TCU_B_FORCE_A 7
`define TCU_B_FORCE_B 6
`define TCU_B_WGM2 3
`define TCU_B_CS 2:0
// flag and interrupt enable bits
`define TCU_F_OVF 0
`define TCU_F_MATCH_A 1
`define TCU_F_MATCH_B 2
// port register bits
`define TCU_P_PORT_A 0
`define TCU_P_PORT_B 1
`define TCU_P_DIR_A 4
`define TCU_P_DIR_B 5

// counter extremes and count step
`define TCU_MAX 8'hFF
`define TCU_BOTTOM 8'h00
`define TCU_ONE 8'h01

// tick source select codes
`define TCU_CS_STOP 3'h0
`define TCU_CS_DIV1 3'h1
`define TCU_CS_DIV8 3'h2
`define TCU_CS_DIV64 3'h3
`define TCU_CS_DIV256 3'h4
`define TCU_CS_DIV1024 3'h5
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7
// prescaler terminal masks
`define TCU_PRE_DIV8 10'h007
`define TCU_PRE_DIV64 10'h03F
`define TCU_PRE_DIV256 10'h0FF
`define TCU_PRE_DIV1024 10'h3FF

// wave mode field codes
`define TCU_WGM_NORMAL 3'h0
`define TCU_WGM_PHASE_MAX 3'h1
`define TCU_WGM_CTC 3'h2
`define TCU_WGM_FAST_MAX 3'h3
`define TCU_WGM_PHASE_CMP 3'h5
`define TCU_WGM_FAST_CMP 3'h7

// compare output action codes
`define TCU_COM_OFF 2'h0
`define TCU_COM_TOGGLE 2'h1
`define TCU_COM_CLEAR 2'h2
`define TCU_COM_SET 2'h3

// reset values and prescaler step
`define TCU_RST8 8'h00
`define TCU_RST3 3'h0
`define TCU_RST2 2'h0
`define TCU_RST_PRE 10'h000
`define TCU_PRE_STEP 10'h001

`endif

// ### rtl/tcu_pkg.sv
/*
 * Types shared by the timer/counter files.
 * Assumes the constants of tcu_map.svh for all numeric codes.
 */
package tcu_pkg;
   // counting sequence class selected by the wave mode field
   typedef enum logic [3:0] {
      TCU_NORMAL = 4'b0001,
      TCU_CTC = 4'b0010,
      TCU_FAST = 4'b0100,
      TCU_PHASE = 4'b1000
   } tcu_mode_t;
endpackage

// ### rtl/tcu_sync2.sv
/*
 * Two-flop synchroniser for one level from outside the core clock.
 * Assumes the input may change at any time relative to core_clk.
 */
`timescale 1ns/1ns
module tcu_sync2 (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ### rtl/tcu_cmp_chan.sv
/*
 * One compare channel: active and buffered compare value, match flag and
 * internal waveform output register.
 * Assumes tick, load and wrap are single-cycle events from the counter.
 */
`timescale 1ns/1ns
`include "tcu_map.svh"
module tcu_cmp_chan
   import tcu_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic [7:0] count,
   input wire logic block,
   input wire logic wr_cmp,
   input wire logic [7:0] wdata,
   input wire tcu_mode_t mode,
   input wire logic load,
   input wire logic wrap,
   input wire logic count_up,
   input wire logic [1:0] com,
   input wire logic toggle_ok,
   input wire logic force_strobe,
   input wire logic flag_clr,
   output logic [7:0] cmp_active,
   output logic [7:0] cmp_read,
   output logic wave,
   output logic flag
);
   logic [7:0] buf_r;
   logic buffered;
   logic nonpwm;
   logic match_evt;
   logic wave_nxt;

   assign buffered = (mode == TCU_FAST) || (mode == TCU_PHASE);
   assign nonpwm = !buffered;
   // comparator runs always, a counter write masks the next tick
   assign match_evt = tick && (count == cmp_active) && !block;
   assign cmp_read = buffered ? buf_r : cmp_active;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_r <= `TCU_RST8;
      end else if (wr_cmp) begin
         buf_r <= wdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_active <= `TCU_RST8;
      end else if (wr_cmp && nonpwm) begin
         cmp_active <= wdata;
      end else if (buffered && load) begin
         cmp_active <= buf_r;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag <= 1'b0;
      end else if (match_evt) begin
         flag <= 1'b1;
      end else if (flag_clr) begin
         flag <= 1'b0;
      end
   end

   // com is read live, so a new action governs the very next match
   always_comb begin
      wave_nxt = wave;
      if (nonpwm) begin
         if (match_evt || force_strobe) begin
            unique case (com)
               `TCU_COM_OFF: wave_nxt = wave;
               `TCU_COM_TOGGLE: wave_nxt = !wave;
               `TCU_COM_CLEAR: wave_nxt = 1'b0;
               `TCU_COM_SET: wave_nxt = 1'b1;
            endcase
         end
      end else if (mode == TCU_FAST && wrap && com[1]) begin
         // bottom beats a match at top so a compare at max stays steady
         wave_nxt = !com[0];
      end else if (match_evt) begin
         if (com == `TCU_COM_TOGGLE && toggle_ok) begin
            wave_nxt = !wave;
         end else if (com[1] && mode == TCU_FAST) begin
            wave_nxt = com[0];
         end else if (com[1]) begin
            wave_nxt = count_up ? com[0] : !com[0];
         end
      end
   end

   // no mode change touches this register, only reset and the compare actions write it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wave <= 1'b0;
      end else begin
         wave <= wave_nxt;
      end
   end
endmodule

// ### rtl/tcu_timer.sv
/*
 * 8-bit up/down timer/counter with two compare channels, APB registers,
 * prescaled or external tick, flags with interrupt requests and pin mux.
 * Assumes an APB master on core_clk and an external pin on any clock.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "tcu_map.svh"

module tcu_timer
   import tcu_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_tick_pin,
   input wire logic irq_ack_ovf,
   input wire logic irq_ack_a,
   input wire logic irq_ack_b,
   output logic irq_ovf,
   output logic irq_cmp_a,
   output logic irq_cmp_b,
   output logic wave_pin_a,
   output logic wave_pin_a_oe,
   output logic wave_pin_b,
   output logic wave_pin_b_oe
);
   // ****************************************************************
   // register bus
   // ****************************************************************
   logic setup;
   logic wr;
   logic hit;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_count;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_flags;
   logic wr_ien;
   logic wr_port;
   logic [7:0] rd_byte;
   logic [1:0] com_a_r;
   logic [1:0] com_b_r;
   logic [2:0] wgm_r;
   logic [2:0] cs_r;
   logic [2:0] ien_r;
   logic [1:0] port_r;
   logic [1:0] dir_r;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic up_r;
   logic up_nxt;
   logic ovf_flag_r;
   logic block_r;
   logic [7:0] cmp_a_act;
   logic [7:0] cmp_a_rd;
   logic [7:0] cmp_b_act;
   logic [7:0] cmp_b_rd;
   logic wave_a;
   logic wave_b;
   logic flag_a;
   logic flag_b;

   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;

   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         `TCU_OFF_CTRL_A: rd_byte = {com_a_r, com_b_r, 2'h0, wgm_r[1:0]};
         // force strobes always read back as zero
         `TCU_OFF_CTRL_B: rd_byte = {4'h0, wgm_r[2], cs_r};
         `TCU_OFF_COUNT: rd_byte = cnt_r;
         `TCU_OFF_CMP_A: rd_byte = cmp_a_rd;
         `TCU_OFF_CMP_B: rd_byte = cmp_b_rd;
         `TCU_OFF_FLAGS: rd_byte = {5'h00, flag_b, flag_a, ovf_flag_r};
         `TCU_OFF_IRQ_EN: rd_byte = {5'h00, ien_r};
         `TCU_OFF_PORT: rd_byte = {2'h0, dir_r, 2'h0, port_r};
         default: begin
            rd_byte = `TCU_RST8;
            hit = 1'b0;
         end
      endcase
   end

   assign pslverr = psel && penable && !hit;
   assign wr_ctrl_a = wr && (paddr == `TCU_OFF_CTRL_A);
   assign wr_ctrl_b = wr && (paddr == `TCU_OFF_CTRL_B);
   assign wr_count = wr && (paddr == `TCU_OFF_COUNT);
   assign wr_cmp_a = wr && (paddr == `TCU_OFF_CMP_A);
   assign wr_cmp_b = wr && (paddr == `TCU_OFF_CMP_B);
   assign wr_flags = wr && (paddr == `TCU_OFF_FLAGS);
   assign wr_ien = wr && (paddr == `TCU_OFF_IRQ_EN);
   assign wr_port = wr && (paddr == `TCU_OFF_PORT);

   // read data is captured in the setup cycle, so it shows that edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         com_a_r <= `TCU_RST2;
         com_b_r <= `TCU_RST2;
         wgm_r <= `TCU_RST3;
         cs_r <= `TCU_RST3;
      end else begin
         if (wr_ctrl_a) begin
            com_a_r <= pwdata[`TCU_A_COM_A];
            com_b_r <= pwdata[`TCU_A_COM_B];
            wgm_r[1:0] <= pwdata[`TCU_A_WGM];
         end
         if (wr_ctrl_b) begin
            wgm_r[2] <= pwdata[`TCU_B_WGM2];
            cs_r <= pwdata[`TCU_B_CS];
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ien_r <= `TCU_RST3;
         port_r <= `TCU_RST2;
         dir_r <= `TCU_RST2;
      end else begin
         if (wr_ien) begin
            ien_r <= pwdata[2:0];
         end
         if (wr_port) begin
            port_r <= {pwdata[`TCU_P_PORT_B], pwdata[`TCU_P_PORT_A]};
            dir_r <= {pwdata[`TCU_P_DIR_B], pwdata[`TCU_P_DIR_A]};
         end
      end
   end

   // ****************************************************************
   // tick source
   // ****************************************************************
   logic [9:0] pre_r;
   logic ext_s;
   logic ext_d_r;
   logic tick;

   tcu_sync2 u_ext_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .async_in(ext_tick_pin),
      .sync_out(ext_s)
   );

   // prescaler free-runs; sharing it keeps tick phase independent of cs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r <= `TCU_RST_PRE;
         ext_d_r <= 1'b0;
      end else begin
         pre_r <= pre_r + `TCU_PRE_STEP;
         ext_d_r <= ext_s;
      end
   end

   always_comb begin
      unique case (cs_r)
         `TCU_CS_STOP: tick = 1'b0;
         `TCU_CS_DIV1: tick = 1'b1;
         `TCU_CS_DIV8: tick = (pre_r & `TCU_PRE_DIV8) == `TCU_PRE_DIV8;
         `TCU_CS_DIV64: tick = (pre_r & `TCU_PRE_DIV64) == `TCU_PRE_DIV64;
         `TCU_CS_DIV256: tick = (pre_r & `TCU_PRE_DIV256) == `TCU_PRE_DIV256;
         `TCU_CS_DIV1024: tick = pre_r == `TCU_PRE_DIV1024;
         `TCU_CS_EXT_FALL: tick = ext_d_r && !ext_s;
         `TCU_CS_EXT_RISE: tick = ext_s && !ext_d_r;
      endcase
   end

   // ****************************************************************
   // counter unit
   // ****************************************************************
   tcu_mode_t mode;
   logic [7:0] top_val;
   logic at_top;
   logic at_max;
   logic at_bot;
   logic ovf_evt;
   logic load_evt;

   always_comb begin
      unique case (wgm_r)
         `TCU_WGM_NORMAL: mode = TCU_NORMAL;
         `TCU_WGM_CTC: mode = TCU_CTC;
         `TCU_WGM_FAST_MAX: mode = TCU_FAST;
         `TCU_WGM_FAST_CMP: mode = TCU_FAST;
         `TCU_WGM_PHASE_MAX: mode = TCU_PHASE;
         `TCU_WGM_PHASE_CMP: mode = TCU_PHASE;
         // reserved codes count as normal
         default: mode = TCU_NORMAL;
      endcase
   end

   always_comb begin
      if (wgm_r == `TCU_WGM_CTC || wgm_r == `TCU_WGM_FAST_CMP ||
          wgm_r == `TCU_WGM_PHASE_CMP) begin
         top_val = cmp_a_act;
      end else begin
         top_val = `TCU_MAX;
      end
   end

   assign at_top = cnt_r == top_val;
   assign at_max = cnt_r == `TCU_MAX;
   assign at_bot = cnt_r == `TCU_BOTTOM;

   always_comb begin
      cnt_nxt = cnt_r + `TCU_ONE;
      up_nxt = 1'b1;
      ovf_evt = 1'b0;
      load_evt = 1'b0;
      unique case (mode)
         TCU_NORMAL: begin
            ovf_evt = at_max;
         end
         TCU_CTC: begin
            if (at_top) begin
               cnt_nxt = `TCU_BOTTOM;
            end
            ovf_evt = at_max;
         end
         TCU_FAST: begin
            if (at_top) begin
               cnt_nxt = `TCU_BOTTOM;
            end
            ovf_evt = at_top;
            load_evt = at_top;
         end
         TCU_PHASE: begin
            if (up_r && at_top) begin
               // a top of zero would wrap, so it holds at bottom
               cnt_nxt = at_bot ? `TCU_BOTTOM : cnt_r - `TCU_ONE;
               up_nxt = 1'b0;
               load_evt = 1'b1;
            end else if (!up_r && !at_bot) begin
               cnt_nxt = cnt_r - `TCU_ONE;
               up_nxt = 1'b0;
            end
            ovf_evt = at_bot;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= `TCU_RST8;
      end else if (wr_count) begin
         cnt_r <= pwdata[7:0];
      end else if (tick) begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_r <= 1'b1;
      end else if (tick && !wr_count) begin
         up_r <= up_nxt;
      end
   end

   // a count write masks matches until the next tick has passed
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         block_r <= 1'b0;
      end else if (wr_count) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   // overflow set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_flag_r <= 1'b0;
      end else if (tick && !wr_count && ovf_evt) begin
         ovf_flag_r <= 1'b1;
      end else if (irq_ack_ovf || (wr_flags && pwdata[`TCU_F_OVF])) begin
         ovf_flag_r <= 1'b0;
      end
   end

   // ****************************************************************
   // compare channels
   // ****************************************************************
   logic load_tick;
   logic wrap_tick;

   assign load_tick = tick && !wr_count && load_evt;
   assign wrap_tick = tick && !wr_count && (mode == TCU_FAST) && at_top;

   tcu_cmp_chan u_chan_a (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .tick(tick),
      .count(cnt_r),
      .block(block_r || wr_count),
      .wr_cmp(wr_cmp_a),
      .wdata(pwdata[7:0]),
      .mode(mode),
      .load(load_tick),
      .wrap(wrap_tick),
      .count_up(up_r),
      .com(com_a_r),
      .toggle_ok(wgm_r[2]),
      .force_strobe(wr_ctrl_b && pwdata[`TCU_B_FORCE_A]),
      .flag_clr(irq_ack_a || (wr_flags && pwdata[`TCU_F_MATCH_A])),
      .cmp_active(cmp_a_act),
      .cmp_read(cmp_a_rd),
      .wave(wave_a),
      .flag(flag_a)
   );

   // toggle in PWM modes exists only on channel a
   tcu_cmp_chan u_chan_b (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .tick(tick),
      .count(cnt_r),
      .block(block_r || wr_count),
      .wr_cmp(wr_cmp_b),
      .wdata(pwdata[7:0]),
      .mode(mode),
      .load(load_tick),
      .wrap(wrap_tick),
      .count_up(up_r),
      .com(com_b_r),
      .toggle_ok(1'b0),
      .force_strobe(wr_ctrl_b && pwdata[`TCU_B_FORCE_B]),
      .flag_clr(irq_ack_b || (wr_flags && pwdata[`TCU_F_MATCH_B])),
      .cmp_active(cmp_b_act),
      .cmp_read(cmp_b_rd),
      .wave(wave_b),
      .flag(flag_b)
   );

   // ****************************************************************
   // requests and pins
   // ****************************************************************
   assign irq_ovf = ovf_flag_r && ien_r[`TCU_F_OVF];
   assign irq_cmp_a = flag_a && ien_r[`TCU_F_MATCH_A];
   assign irq_cmp_b = flag_b && ien_r[`TCU_F_MATCH_B];

   assign wave_pin_a = (com_a_r != `TCU_COM_OFF) ? wave_a : port_r[0];
   assign wave_pin_b = (com_b_r != `TCU_COM_OFF) ? wave_b : port_r[1];
   assign wave_pin_a_oe = dir_r[0];
   assign wave_pin_b_oe = dir_r[1];
endmodule

// ### tb/tcu_timer_checker.sv
/*
 * Port checker for the timer: shadows apb writes and ties pins to them.
 * Assumes the offsets of tcu_map.svh and a single core_clk domain.
 */
`timescale 1ns/1ns
`include "tcu_map.svh"
module tcu_timer_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_tick_pin,
   input wire logic irq_ack_ovf,
   input wire logic irq_ack_a,
   input wire logic irq_ack_b,
   input wire logic irq_ovf,
   input wire logic irq_cmp_a,
   input wire logic irq_cmp_b,
   input wire logic wave_pin_a,
   input wire logic wave_pin_a_oe,
   input wire logic wave_pin_b,
   input wire logic wave_pin_b_oe
);
   logic wr;
   logic [7:0] port_r, cta_r, ien_r;
   logic [2:0] cs_r;
   assign wr = psel && penable && pwrite && pready;
   // shadows follow the bus, so a dead register inside shows up as skew
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         port_r <= 8'h00;
         cta_r <= 8'h00;
         ien_r <= 8'h00;
         cs_r <= 3'h0;
      end else if (wr) begin
         if (paddr == `TCU_OFF_PORT) port_r <= pwdata[7:0];
         if (paddr == `TCU_OFF_CTRL_A) cta_r <= pwdata[7:0];
         if (paddr == `TCU_OFF_IRQ_EN) ien_r <= pwdata[7:0];
         if (paddr == `TCU_OFF_CTRL_B) cs_r <= pwdata[2:0];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_ready; pready; endproperty
   property p_err; pslverr |-> psel && penable; endproperty
   property p_hi; prdata[31:8] == 24'h0; endproperty
   property p_oe;
      {wave_pin_b_oe, wave_pin_a_oe} == {port_r[5], port_r[4]};
   endproperty
   property p_pin_a; cta_r[7:6] == 2'h0 |-> wave_pin_a == port_r[0];
   endproperty
   property p_pin_b; cta_r[5:4] == 2'h0 |-> wave_pin_b == port_r[1];
   endproperty
   property p_irq;
      ({irq_cmp_b, irq_cmp_a, irq_ovf} & ~ien_r[2:0]) == 3'h0;
   endproperty
   property p_ack; irq_ack_ovf && cs_r == 3'h0 |=> !irq_ovf; endproperty
   property p_hold;
      cs_r == 3'h0 && !wr |=> $stable({wave_pin_b, wave_pin_a});
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready not high");
   a_err: assert property (p_err)
      else $error("slave error outside access phase");
   a_hi: assert property (p_hi)
      else $error("read data above bit 7 not zero");
   a_oe: assert property (p_oe)
      else $error("pin enables differ from direction bits");
   a_pin_a: assert property (p_pin_a)
      else $error("pin a not port bit with action off");
   a_pin_b: assert property (p_pin_b)
      else $error("pin b not port bit with action off");
   a_irq: assert property (p_irq)
      else $error("interrupt request while disabled");
   a_ack: assert property (p_ack)
      else $error("overflow request survives service");
   a_hold: assert property (p_hold)
      else $error("wave pins moved while stopped and idle");
   c_err: cover property (pslverr);
   c_ovf: cover property (irq_ovf);
   c_ack: cover property (irq_ack_ovf && cs_r == 3'h0);
endmodule

// ### tb/testbench.sv
/*
 * Self-checking bench for tcu_timer: apb driver, read monitor, pin checks.
 * Assumes a 250 MHz core_clk and the offsets of tcu_map.svh.
 */
`timescale 1ns/1ns
`include "tcu_map.svh"
module testbench;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_tick_pin = 1'b0, irq_ack_ovf = 1'b0;
   logic irq_ack_a = 1'b0, irq_ack_b = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq_ovf, irq_cmp_a, irq_cmp_b;
   logic wave_pin_a, wave_pin_a_oe, wave_pin_b, wave_pin_b_oe;
   integer n_fail = 0, n_tests = 0, seed = 32'hA772;
   logic [32:0] exp_q[$];
   logic [7:0] r, p;
   int n;

   always #2 core_clk = ~core_clk;

   tcu_timer DUT (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ext_tick_pin, .irq_ack_ovf,
      .irq_ack_a, .irq_ack_b, .irq_ovf, .irq_cmp_a, .irq_cmp_b,
      .wave_pin_a, .wave_pin_a_oe, .wave_pin_b, .wave_pin_b_oe);

   // ****************************************
   // tasks
   // ****************************************
   task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   // one-cycle service pulse on the chosen acknowledge inputs
   task svc(input logic [2:0] k);
      @(posedge core_clk);
      {irq_ack_b, irq_ack_a, irq_ack_ovf} <= k;
      @(posedge core_clk);
      {irq_ack_b, irq_ack_a, irq_ack_ovf} <= 3'h0;
   endtask

   // the note goes in before the transfer so the monitor finds it waiting
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({25'h0, e});
      apb(1'b0, a, 8'h00);
   endtask

   task rd_bad(input logic [7:0] a);
      exp_q.push_back({1'b1, 32'h0});
      apb(1'b0, a, 8'h00);
   endtask

   // one pulse per tick; gaps exceed the synchroniser delay
   task tick(input int k);
      repeat (k) begin
         ext_tick_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         ext_tick_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask

   task pins(input logic a, input logic b);
      @(negedge core_clk);
      chk("wave pin a", 33'(a), 33'(wave_pin_a));
      chk("wave pin b", 33'(b), 33'(wave_pin_b));
   endtask

   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready && exp_q.size() > 0) begin
         chk("read data", exp_q.pop_front(),
            {pslverr, prdata});
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      end_of_test;
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
      rd_bad(8'h20);
      rd_bad(8'h02);
      p = 8'h30 | 8'($random(seed) & 3);
      wr(`TCU_OFF_PORT, p);
      pins(p[0], p[1]);
      chk("pin enables", 33'h3,
         {31'h0, wave_pin_b_oe, wave_pin_a_oe});
      for (int cs = 6; cs < 8; cs++) begin
         r = 8'h30 + 8'($random(seed) & 8'h7F);
         n = 1 + ($random(seed) & 7);
         wr(`TCU_OFF_COUNT, r);
         wr(`TCU_OFF_CTRL_B, 8'(cs));
         tick(n);
         wr(`TCU_OFF_CTRL_B, 8'h00);
         tick(2);
         rd(`TCU_OFF_COUNT, r + 8'(n));
      end
      wr(`TCU_OFF_FLAGS, 8'h07);
      wr(`TCU_OFF_COUNT, 8'hFE);
      wr(`TCU_OFF_CTRL_B, 8'h07);
      wr(`TCU_OFF_IRQ_EN, 8'h01);
      tick(2);
      rd(`TCU_OFF_COUNT, 8'h00);
      rd(`TCU_OFF_FLAGS, 8'h01);
      @(negedge core_clk);
      chk("overflow request", 33'h1, 33'(irq_ovf));
      wr(`TCU_OFF_CTRL_B, 8'h00);
      svc(3'h1);
      rd(`TCU_OFF_FLAGS, 8'h00);
      wr(`TCU_OFF_CMP_A, 8'h10);
      wr(`TCU_OFF_CMP_B, 8'h80);
      wr(`TCU_OFF_CTRL_A, 8'h40);
      wr(`TCU_OFF_CTRL_B, 8'h07);
      // equal count written: the first tick must not match
      wr(`TCU_OFF_COUNT, 8'h10);
      tick(1);
      rd(`TCU_OFF_FLAGS, 8'h00);
      pins(1'b0, p[1]);
      wr(`TCU_OFF_COUNT, 8'h0E);
      tick(3);
      rd(`TCU_OFF_COUNT, 8'h11);
      rd(`TCU_OFF_FLAGS, 8'h02);
      pins(1'b1, p[1]);
      wr(`TCU_OFF_FLAGS, 8'h02);
      rd(`TCU_OFF_FLAGS, 8'h00);
      wr(`TCU_OFF_CTRL_B, 8'h00);
      for (int c = 3; c > 0; c--) begin
         wr(`TCU_OFF_CTRL_A, 8'h40 | 8'(c << 4));
         wr(`TCU_OFF_CTRL_B, 8'h40);
         pins(1'b1, c != 2);
      end
      wr(`TCU_OFF_CTRL_B, 8'h80);
      pins(1'b0, 1'b1);
      rd(`TCU_OFF_FLAGS, 8'h00);
      rd(`TCU_OFF_COUNT, 8'h11);
      wr(`TCU_OFF_CTRL_A, 8'h42);
      wr(`TCU_OFF_CMP_A, 8'h05);
      wr(`TCU_OFF_COUNT, 8'h00);
      wr(`TCU_OFF_CTRL_B, 8'h07);
      tick(7);
      rd(`TCU_OFF_COUNT, 8'h01);
      rd(`TCU_OFF_FLAGS, 8'h02);
      pins(1'b1, p[1]);
      wr(`TCU_OFF_IRQ_EN, 8'h02);
      @(negedge core_clk);
      chk("match a request", 33'h1, 33'(irq_cmp_a));
      svc(3'h2);
      rd(`TCU_OFF_FLAGS, 8'h00);
      wr(`TCU_OFF_FLAGS, 8'h07);
      wr(`TCU_OFF_CTRL_A, 8'h03);
      wr(`TCU_OFF_COUNT, 8'h7E);
      wr(`TCU_OFF_CMP_B, 8'h20);
      rd(`TCU_OFF_CMP_B, 8'h20);
      tick(3);
      rd(`TCU_OFF_FLAGS, 8'h04);
      wr(`TCU_OFF_IRQ_EN, 8'h04);
      @(negedge core_clk);
      chk("match b request", 33'h1, 33'(irq_cmp_b));
      svc(3'h4);
      rd(`TCU_OFF_FLAGS, 8'h00);
      wr(`TCU_OFF_CTRL_A, 8'h40);
      rd(`TCU_OFF_CMP_B, 8'h80);
      pins(1'b1, p[1]);
      // preset wave a low by force in normal mode, then run fast pwm
      wr(`TCU_OFF_CTRL_B, 8'h80);
      wr(`TCU_OFF_CTRL_A, 8'h83);
      wr(`TCU_OFF_COUNT, 8'hFE);
      wr(`TCU_OFF_CTRL_B, 8'h07);
      tick(2);
      pins(1'b1, p[1]);
      tick(6);
      pins(1'b0, p[1]);
      rd(`TCU_OFF_FLAGS, 8'h03);
      wr(`TCU_OFF_CTRL_B, 8'h00);
      repeat (4) @(posedge core_clk);
      end_of_test;
   end
endmodule

bind tcu_timer tcu_timer_checker u_chk (.core_clk, .arst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .ext_tick_pin, .irq_ack_ovf, .irq_ack_a, .irq_ack_b, .irq_ovf,
   .irq_cmp_a, .irq_cmp_b, .wave_pin_a, .wave_pin_a_oe, .wave_pin_b,
   .wave_pin_b_oe);
